// ==== logic/smg_pkg.sv ====
// Package with constants and types for the sample marker generator.
// Functional notes
// - Granularity 48/40/24/24/24/48 by output mode.
// - Single marked sample gives one-granule pulse.
// - Consecutive marked samples merge into one pulse.
// - Pulse length rounded to whole granules.
// - Sample marker follows channel delay like data.
// - Short gaps may merge into one pulse.
// - Pulse rises exactly at first marked sample.
// - Marker end may vary when loops occur.
// - Offset-started segments may show marker gaps.
// - Vector marker set once per sync period.
// - Vector marker ignores channel delay setting.
// - Action-table changes apply at next sample marker.
package smg_pkg;

    // Output modes of the channel.
    typedef enum logic [2:0] {
        SMG_HIGH_SPEED          = 3'h0,
        SMG_HIGH_PRECISION      = 3'h1,
        SMG_INTERP_BY_THREE     = 3'h2,
        SMG_INTERP_BY_TWELVE    = 3'h3,
        SMG_INTERP_BY_TWENTYFOUR = 3'h4,
        SMG_INTERP_BY_FORTYEIGHT = 3'h5
    } smg_mode_t;

    // Granularity in DAC samples for each mode.
    localparam logic [7:0] SMG_GRAN_HIGH_SPEED     = 8'h30;
    localparam logic [7:0] SMG_GRAN_HIGH_PRECISION = 8'h28;
    localparam logic [7:0] SMG_GRAN_INTERP_SHORT   = 8'h18;
    localparam logic [7:0] SMG_GRAN_INTERP_LONG    = 8'h30;

    // Sample width and maximum channel delay depth.
    localparam int SMG_SAMPLE_W  = 16;
    localparam int SMG_DELAY_MAX = 64;
    localparam int SMG_DELAY_W   = 6;

    // Sample word with its marker flag.
    typedef struct packed {
        logic                    mark;
        logic [SMG_SAMPLE_W-1:0] data;
    } smg_word_t;

    // Pending configuration word from the action table.
    typedef struct packed {
        logic        valid;
        logic [15:0] value;
    } smg_cfg_t;

endpackage

// ==== logic/smg_delay_line.sv ====
// Programmable delay line carrying sample words with their marker flags.
`timescale 1ns/1ps
module smg_delay_line
    import smg_pkg::*;
#(
    parameter int DEPTH = SMG_DELAY_MAX,
    parameter int AW    = SMG_DELAY_W
) (
    // Clock and reset.
    input  wire logic          clk,
    input  wire logic          arst_n,
    // Delay setting in samples.
    input  wire logic [AW-1:0] delay,
    // Word in and out.
    input  wire smg_word_t     word_in,
    output smg_word_t          word_out
);

    smg_word_t       line_q [DEPTH];
    logic [AW-1:0]   wr_q;
    logic [AW-1:0]   rd_idx;

    // Read index trails the write index by the delay.
    assign rd_idx = wr_q - delay;

    // Circular store of words; marker and data share one slot.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                line_q[i] <= '0;
            end
        end else begin
            line_q[wr_q] <= word_in;
            wr_q         <= wr_q + 1'b1;
        end
    end

    // Delayed output selected from the store.
    assign word_out = line_q[rd_idx];

endmodule

// ==== logic/smg_top.sv ====
// Top of the sample marker generator: quantised sample marker and vector marker.
`timescale 1ns/1ps
module smg_top
    import smg_pkg::*;
#(
    parameter int VEC_LEN = 48
) (
    // Clock and reset.
    input  wire logic                    SYS_CLK,
    input  wire logic                    ARST_N,
    // Mode and channel delay.
    input  wire logic [2:0]              MODE,
    input  wire logic [SMG_DELAY_W-1:0]  CHAN_DELAY,
    // Sample stream with marker flag.
    input  wire logic [SMG_SAMPLE_W-1:0] SAMPLE_IN,
    input  wire logic                    SAMPLE_MARK,
    // Vector marker request, sampled per sync period.
    input  wire logic                    VECTOR_MARK_REQ,
    // Action table configuration.
    input  wire logic                    CFG_VALID,
    input  wire logic [15:0]             CFG_VALUE,
    // Outputs.
    output logic [SMG_SAMPLE_W-1:0]      SAMPLE_OUT,
    output logic                         SAMPLE_MARKER,
    output logic                         VECTOR_MARKER,
    output logic                         SYNC_CLK_OUT,
    output logic [15:0]                  CFG_ACTIVE
);

    // Granularity lookup for a mode code.
    function automatic logic [7:0] gran_of(input logic [2:0] m);
        case (m)
            SMG_HIGH_SPEED:           gran_of = SMG_GRAN_HIGH_SPEED;
            SMG_HIGH_PRECISION:       gran_of = SMG_GRAN_HIGH_PRECISION;
            SMG_INTERP_BY_THREE:      gran_of = SMG_GRAN_INTERP_SHORT;
            SMG_INTERP_BY_TWELVE:     gran_of = SMG_GRAN_INTERP_SHORT;
            SMG_INTERP_BY_TWENTYFOUR: gran_of = SMG_GRAN_INTERP_SHORT;
            SMG_INTERP_BY_FORTYEIGHT: gran_of = SMG_GRAN_INTERP_LONG;
            default:                  gran_of = SMG_GRAN_HIGH_SPEED;
        endcase
    endfunction

    smg_word_t   word_in;
    smg_word_t   word_dly;
    logic [7:0]  gran;
    logic [7:0]  cnt_q;
    logic [7:0]  cnt_d;
    logic        active_q;
    logic        active_d;
    logic        pend_q;
    logic        pend_d;
    logic        rise;
    logic        marker_d;
    logic [7:0]  vec_q;
    logic        vec_last;
    logic        vreq_q;
    logic        vreq_d;
    logic        vec_mark_d;
    smg_cfg_t    cfg_q;
    smg_cfg_t    cfg_d;
    logic [SMG_SAMPLE_W-1:0] data_q;
    logic        marker_q;
    logic        vec_mark_q;
    logic        sync_q;
    logic [15:0] cfg_act_q;

    assign word_in = '{mark: SAMPLE_MARK, data: SAMPLE_IN};

    // Delay line shifts marker and data together.
    smg_delay_line #(
        .DEPTH (SMG_DELAY_MAX),
        .AW    (SMG_DELAY_W)
    ) u_delay (
        .clk      (SYS_CLK),
        .arst_n   (ARST_N),
        .delay    (CHAN_DELAY),
        .word_in  (word_in),
        .word_out (word_dly)
    );

    assign gran = gran_of(MODE);

    // Pulse timing: start at a mark, run whole granules while marks keep coming.
    assign rise     = word_dly.mark && !active_q;
    assign pend_d   = active_q && (cnt_q != 8'h01) ? (pend_q | word_dly.mark) : 1'b0;
    assign active_d = rise ? 1'b1 :
                      (active_q && cnt_q == 8'h01) ? (pend_q | word_dly.mark) : active_q;
    assign cnt_d    = rise ? gran :
                      (active_q && cnt_q == 8'h01) ? ((pend_q | word_dly.mark) ? gran : 8'h00) :
                      (active_q ? cnt_q - 8'h01 : 8'h00);
    assign marker_d = active_d;

    // Vector counter marks sync periods.
    assign vec_last   = (vec_q == 8'(VEC_LEN - 1));
    assign vreq_d     = vec_last ? 1'b0 : (vreq_q | VECTOR_MARK_REQ);
    assign vec_mark_d = vec_last ? (vreq_q | VECTOR_MARK_REQ) : vec_mark_q;

    // Pending config held until the next marker rises; a new write wins.
    assign cfg_d = CFG_VALID ? '{valid: 1'b1, value: CFG_VALUE} :
                   (rise ? '{valid: 1'b0, value: cfg_q.value} : cfg_q);

    // Marker state registers.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_q    <= 8'h00;
            active_q <= 1'b0;
            pend_q   <= 1'b0;
            marker_q <= 1'b0;
            data_q   <= '0;
        end else begin
            cnt_q    <= cnt_d;
            active_q <= active_d;
            pend_q   <= pend_d;
            marker_q <= marker_d;
            data_q   <= word_dly.data;
        end
    end

    // Vector marker registers run on undelayed timing.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            vec_q      <= 8'h00;
            vreq_q     <= 1'b0;
            vec_mark_q <= 1'b0;
            sync_q     <= 1'b0;
        end else begin
            vec_q      <= vec_last ? 8'h00 : vec_q + 8'h01;
            vreq_q     <= vreq_d;
            vec_mark_q <= vec_mark_d;
            sync_q     <= vec_last || (vec_q < 8'(VEC_LEN / 2 - 1));
        end
    end

    // Configuration applies at the marker rise.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg_q     <= '0;
            cfg_act_q <= 16'h0000;
        end else begin
            cfg_q <= cfg_d;
            if (rise && cfg_q.valid) begin
                cfg_act_q <= cfg_q.value;
            end
        end
    end

    assign SAMPLE_OUT    = data_q;
    assign SAMPLE_MARKER = marker_q;
    assign VECTOR_MARKER = vec_mark_q;
    assign SYNC_CLK_OUT  = sync_q;
    assign CFG_ACTIVE    = cfg_act_q;

endmodule

// ==== testbench/smg_top_asserts.sv ====
// Port checker for the sample marker generator.
`timescale 1ns/1ps
module smg_top_asserts
    import smg_pkg::*;
#(
    parameter int VEC_LEN = 48
) (
    // Clock, reset and watched ports.
    input wire logic                    SYS_CLK,
    input wire logic                    ARST_N,
    input wire logic [2:0]              MODE,
    input wire logic [SMG_DELAY_W-1:0]  CHAN_DELAY,
    input wire logic [SMG_SAMPLE_W-1:0] SAMPLE_IN,
    input wire logic                    SAMPLE_MARK,
    input wire logic [SMG_SAMPLE_W-1:0] SAMPLE_OUT,
    input wire logic                    SAMPLE_MARKER,
    input wire logic                    VECTOR_MARKER,
    input wire logic                    SYNC_CLK_OUT,
    input wire logic [15:0]             CFG_ACTIVE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    logic [15:0] run_q;
    logic [15:0] vrun_q;
    logic [15:0] gran;
    // Granule length of the selected mode.
    assign gran = (MODE == 3'h1) ? 16'h28 : (MODE inside {3'h2, 3'h3, 3'h4}) ? 16'h18 : 16'h30;
    // Lengths of the current high runs on both markers.
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            run_q  <= 16'h0;
            vrun_q <= 16'h0;
        end else begin
            run_q  <= SAMPLE_MARKER ? run_q + 16'h1 : 16'h0;
            vrun_q <= VECTOR_MARKER ? vrun_q + 16'h1 : 16'h0;
        end
    end
    // A delay of one sample held long enough to fill the pipe.
    sequence s_d1;
        CHAN_DELAY == 6'h1 && $past(CHAN_DELAY, 3) == 6'h1;
    endsequence
    a_data_aligned: assert property (s_d1 |-> SAMPLE_OUT == $past(SAMPLE_IN, 2))
        else $error("data out of step");
    a_rise_at_mark: assert property (s_d1 ##0 $rose(SAMPLE_MARKER) |-> $past(SAMPLE_MARK, 2))
        else $error("rise without mark");
    a_mark_covered: assert property (s_d1 ##0 SAMPLE_MARK |-> ##2 SAMPLE_MARKER)
        else $error("mark not covered");
    a_min_granule: assert property (SAMPLE_MARKER && run_q < gran - 16'h1 |=> SAMPLE_MARKER)
        else $error("pulse too short");
    a_whole_granules: assert property ($fell(SAMPLE_MARKER) |-> run_q % gran == 0 && run_q != 0)
        else $error("pulse not whole");
    a_vector_period: assert property ($fell(VECTOR_MARKER) |-> vrun_q % VEC_LEN == 0)
        else $error("vector width wrong");
    a_vector_on_sync: assert property ($rose(VECTOR_MARKER) |-> $rose(SYNC_CLK_OUT))
        else $error("vector off sync");
    a_cfg_at_rise: assert property ($changed(CFG_ACTIVE) |-> $rose(SAMPLE_MARKER))
        else $error("config off marker");
endmodule

// ==== testbench/smg_pulse_meter.sv ====
// Pulse meter standing for the outside equipment on a marker pin.
`timescale 1ns/1ps
module smg_pulse_meter (
    // Clock, reset, pin and last pulse width.
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        pin,
    output logic      [15:0] width_q
);
    logic [15:0] run_q;
    // Count high cycles and keep the run length when the pin falls.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_q   <= 16'h0;
            width_q <= 16'h0;
        end else begin
            run_q <= pin ? run_q + 16'h1 : 16'h0;
            if (!pin && run_q != 16'h0) begin
                width_q <= run_q;
            end
        end
    end
endmodule

// ==== testbench/test_smg_top.sv ====
// Self-checking bench for the sample marker generator.
`timescale 1ns/1ps
module test_smg_top;
    import smg_pkg::*;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [2:0]  mode = 3'h0;
    logic [5:0]  dly = 6'h1;
    logic [15:0] din = 16'h0;
    logic        mark = 1'b0;
    logic        vreq = 1'b0;
    logic        cfg_v = 1'b0;
    logic [15:0] cfg_val = 16'h0;
    logic [15:0] dout, cfg_act, sw, vw;
    logic        smark, vmark;
    int          err_count = 0;
    int          n_compared = 0;
    // Clock, design and the two pin meters.
    always #5 clk = ~clk;
    smg_top smg_top_inst (.SYS_CLK(clk), .ARST_N(arst_n), .MODE(mode), .CHAN_DELAY(dly),
        .SAMPLE_IN(din), .SAMPLE_MARK(mark), .VECTOR_MARK_REQ(vreq), .CFG_VALID(cfg_v),
        .CFG_VALUE(cfg_val), .SAMPLE_OUT(dout), .SAMPLE_MARKER(smark),
        .VECTOR_MARKER(vmark), .SYNC_CLK_OUT(), .CFG_ACTIVE(cfg_act));
    smg_pulse_meter smg_pulse_meter_inst (.clk(clk), .arst_n(arst_n), .pin(smark), .width_q(sw));
    smg_pulse_meter vec_meter_inst (.clk(clk), .arst_n(arst_n), .pin(vmark), .width_q(vw));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic pulse(input int n);
        mark <= 1'b1;
        tick(n);
        mark <= 1'b0;
    endtask
    task automatic t_modes();
        logic [15:0] g [6] = '{16'h30, 16'h28, 16'h18, 16'h18, 16'h18, 16'h30};
        for (int m = 0; m < 6; m++) begin
            mode <= 3'(m);
            tick(2);
            pulse(1);
            tick(130);
            chk(sw, g[m]);
        end
        mode <= 3'h0;
    endtask
    task automatic t_run();
        pulse(49);
        tick(150);
        chk(sw, 16'h60);
    endtask
    task automatic t_delay();
        dly <= 6'h5;
        din <= 16'h1234;
        pulse(1);
        din <= 16'h0;
        tick(4);
        #1 chk({15'h0, smark}, 16'h0);
        tick(1);
        #1 chk({15'h0, smark}, 16'h1);
        chk(dout, 16'h1234);
        tick(80);
    endtask
    task automatic t_vector();
        vreq <= 1'b1;
        tick(1);
        vreq <= 1'b0;
        tick(200);
        chk(vw, 16'h30);
        dly <= 6'h1;
        tick(10);
    endtask
    task automatic t_cfg();
        cfg_v <= 1'b1;
        cfg_val <= 16'h00a5;
        tick(1);
        cfg_v <= 1'b0;
        tick(20);
        #1 chk(cfg_act, 16'h0);
        tick(1);
        pulse(1);
        tick(4);
        #1 chk(cfg_act, 16'h00a5);
    endtask
    task automatic final_report();
        if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Main sequence and the watchdog.
    initial begin
        tick(2);
        arst_n <= 1'b1;
        tick(1);
        t_modes();
        t_run();
        t_delay();
        t_vector();
        t_cfg();
        final_report();
    end
    initial begin
        tick(4000);
        err_count++;
        final_report();
    end
endmodule
bind smg_top smg_top_asserts #(.VEC_LEN(VEC_LEN)) smg_top_asserts_inst (.*);
